/* shared/vixc_pkg.sv */
// Constants shared by the video input exclusion control design.
package vixc_pkg;
    // Matrix size
    localparam int NUM_INPUTS = 16; // Video inputs
    localparam int NUM_OUTPUTS = 4; // Monitor outputs
    localparam int IN_W = 4; // Input index width
    localparam int OUT_W = 2; // Output index width
    // Fixed roles of outputs (zero-based index)
    localparam logic [OUT_W-1:0] MASTER_OUT = 2'h0; // Monitor 1
    localparam logic [OUT_W-1:0] RECORDER_OUT = 2'h3; // Monitor 4
    // Keyboard number that acts as master position
    localparam logic [3:0] MASTER_KEYBOARD = 4'h1;
    // Keyboard command codes
    localparam logic [1:0] CMD_SELECT = 2'h0; // Direct selection
    localparam logic [1:0] CMD_STEP_NEXT = 2'h1; // Next input
    localparam logic [1:0] CMD_STEP_PREV = 2'h2; // Previous input
    localparam logic [1:0] CMD_SEQUENCE = 2'h3; // sequence_resume_key
    // Exclusion mode select
    localparam logic MODE_MANUAL = 1'h0;
    localparam logic MODE_TELEMETRY = 1'h1;
    // Telemetry path select
    localparam logic PATH_AUX = 1'h0;
    localparam logic PATH_COAX = 1'h1;
    // Auxiliary line protocol select and their frame headers
    localparam logic [1:0] AUX_NATIVE = 2'h0;
    localparam logic [1:0] AUX_PROTO_A = 2'h1;
    localparam logic [1:0] AUX_PROTO_B = 2'h2;
    localparam logic [1:0] AUX_PROTO_C = 2'h3;
    localparam logic [7:0] HDR_NATIVE = 8'hA0;
    localparam logic [7:0] HDR_PROTO_A = 8'hB1;
    localparam logic [7:0] HDR_PROTO_B = 8'hC2;
    localparam logic [7:0] HDR_PROTO_C = 8'hFF;
    // Reset values
    localparam logic [IN_W-1:0] RST_INPUT = 4'h0;
    localparam logic RST_AUTO = 1'h1; // Monitors start in sequence
    // Exclusion state machine
    typedef enum logic [1:0] {
        EX_IDLE = 2'b00,
        EX_MANUAL = 2'b01,
        EX_TELEM = 2'b10
    } vixc_excl_e;
endpackage

/* design/vixc_aux_xlat.sv */
// Translates keyboard telemetry into the auxiliary line device protocol.
`timescale 1ns/1ps
module vixc_aux_xlat (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [1:0] proto,
    input wire logic in_valid,
    input wire logic [4:0] in_addr,
    input wire logic [7:0] in_op,
    output logic out_valid,
    output logic [7:0] out_hdr,
    output logic [7:0] out_addr,
    output logic [7:0] out_op
);
    logic [7:0] hdr_d; // Header for chosen protocol
    logic [7:0] addr_d; // Address as the device counts it
    logic [7:0] op_d; // Opcode in device encoding

    // Protocol specific framing; some devices count receivers from zero
    assign hdr_d = (proto == vixc_pkg::AUX_NATIVE) ? vixc_pkg::HDR_NATIVE :
                   (proto == vixc_pkg::AUX_PROTO_A) ? vixc_pkg::HDR_PROTO_A :
                   (proto == vixc_pkg::AUX_PROTO_B) ? vixc_pkg::HDR_PROTO_B :
                   vixc_pkg::HDR_PROTO_C; // R16
    assign addr_d = (proto == vixc_pkg::AUX_PROTO_C) ?
                    {3'h0, in_addr} - 8'h01 : {3'h0, in_addr}; // R16
    // Protocol B carries the opcode nibbles swapped
    assign op_d = (proto == vixc_pkg::AUX_PROTO_B) ?
                  {in_op[3:0], in_op[7:4]} : in_op; // R16

    // Output frame register, one cycle after the request
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            out_valid <= 1'b0;
            out_hdr <= 8'h00;
            out_addr <= 8'h00;
            out_op <= 8'h00;
        end else begin
            out_valid <= in_valid;
            if (in_valid) begin
                out_hdr <= hdr_d;
                out_addr <= addr_d;
                out_op <= op_d;
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    aux_frame_a: assert property (in_valid |=> out_valid &&
        out_hdr == $past(hdr_d)) // R16
        else $error("aux frame not produced");
endmodule

/* design/vixc_ctrl.sv */
// Monitor routing and video input exclusion control of a matrix switcher.
//
// Contract
// R1 - Switching one monitor leaves others unchanged
// R2 - Manual or telemetry exclusion, chosen by config
// R3 - Exclude only on monitors running auto sequence
// R4 - Output 1 is always the master monitor
// R5 - Never exclude on the recorder output
// R6 - Recorder output 4 follows trigger, ignores keyboards
// R7 - Advisory overlay on master while excluding
// R8 - Any alarm removes the advisory overlay
// R9 - Replacement camera substitutes excluded input
// R10 - Replacement keeps slot, original returns afterwards
// R11 - Manual: master selection or step excludes input
// R12 - Manual: sequence key on master ends exclusion
// R13 - Telemetry from keyboard 1 starts exclusion
// R14 - Telemetry mode: selections alone do not exclude
// R15 - Telemetry mode: sequence key ends exclusion
// R16 - Translate aux line messages to device protocol
// R17 - Coax receiver address equals input number
`timescale 1ns/1ps
module vixc_ctrl #(
    parameter int NUM_IN = vixc_pkg::NUM_INPUTS,
    parameter int NUM_OUT = vixc_pkg::NUM_OUTPUTS
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic cfg_mode,
    input wire logic [vixc_pkg::IN_W-1:0] cfg_repl,
    input wire logic cfg_rec_en,
    input wire logic [1:0] cfg_aux_proto,
    input wire logic kbd_valid,
    input wire logic [1:0] kbd_cmd,
    input wire logic [vixc_pkg::OUT_W-1:0] kbd_out,
    input wire logic [vixc_pkg::IN_W-1:0] kbd_in,
    input wire logic tel_valid,
    input wire logic [3:0] tel_kbd,
    input wire logic [vixc_pkg::IN_W-1:0] tel_in,
    input wire logic tel_path,
    input wire logic [7:0] tel_op,
    input wire logic [NUM_OUT-1:0][vixc_pkg::IN_W-1:0] seq_in,
    input wire logic alarm_pin,
    input wire logic rec_trig_pin,
    input wire logic [vixc_pkg::IN_W-1:0] rec_in,
    output logic [NUM_OUT-1:0][vixc_pkg::IN_W-1:0] mon_vid,
    output logic [NUM_OUT-1:0] mon_auto,
    output logic excl_active,
    output logic [vixc_pkg::IN_W-1:0] excl_input,
    output logic overlay_on,
    output logic coax_valid,
    output logic [4:0] coax_addr,
    output logic [7:0] coax_op,
    output logic aux_valid,
    output logic [7:0] aux_hdr,
    output logic [7:0] aux_addr,
    output logic [7:0] aux_op
);
    localparam int IW = vixc_pkg::IN_W;
    localparam logic [IW-1:0] LAST_IN = IW'(NUM_IN - 1); // Wrap point

    // Pin synchronisers; first stages feed only second stages
    logic alarm_s1_q, alarm_q; // Alarm display level
    logic trig_s1_q, trig_q, trig_old_q; // Recorder trigger
    logic trig_rise; // Trigger edge pulse
    // Per monitor state
    logic [NUM_OUT-1:0][IW-1:0] sel_q, sel_d; // Manual selection
    logic [NUM_OUT-1:0] auto_q, auto_d; // Sequence running
    logic [NUM_OUT-1:0][IW-1:0] vid_d; // Routed input
    logic [NUM_OUT-1:0] hit; // Keyboard command for monitor
    logic [NUM_OUT-1:0] pub; // Subject to exclusion
    // Exclusion state
    vixc_pkg::vixc_excl_e state_q, state_d;
    logic [IW-1:0] excl_in_q, excl_in_d;
    logic overlay_q; // Advisory overlay
    logic rec_ded; // Output 4 reserved for recorder
    logic master_hit, seq_master, man_pick, tel_trig;
    logic coax_req, aux_req;
    logic coax_valid_q;
    logic [4:0] coax_addr_q;
    logic [7:0] coax_op_q;

    // Two stage synchronisers and trigger edge register
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            alarm_s1_q <= 1'b0;
            alarm_q <= 1'b0;
            trig_s1_q <= 1'b0;
            trig_q <= 1'b0;
            trig_old_q <= 1'b0;
        end else begin
            alarm_s1_q <= alarm_pin;
            alarm_q <= alarm_s1_q;
            trig_s1_q <= rec_trig_pin;
            trig_q <= trig_s1_q;
            trig_old_q <= trig_q;
        end
    end
    assign trig_rise = trig_q & ~trig_old_q;

    // Command decode
    assign rec_ded = cfg_rec_en;
    assign master_hit = kbd_valid && (kbd_out == vixc_pkg::MASTER_OUT); // R4
    assign seq_master = master_hit && (kbd_cmd == vixc_pkg::CMD_SEQUENCE);
    // Any non-sequence command on the master picks a camera
    assign man_pick = master_hit && (kbd_cmd != vixc_pkg::CMD_SEQUENCE) &&
                      (cfg_mode == vixc_pkg::MODE_MANUAL); // R2 R11 R14
    // Only the master keyboard's telemetry counts
    assign tel_trig = tel_valid && (tel_kbd == vixc_pkg::MASTER_KEYBOARD) &&
                      (cfg_mode == vixc_pkg::MODE_TELEMETRY); // R2 R13

    // Per monitor selection and routing
    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUT; gi++) begin : g_mon
            localparam logic [vixc_pkg::OUT_W-1:0] IDX =
                vixc_pkg::OUT_W'(gi);
            logic is_rec; // This output belongs to the recorder
            logic [IW-1:0] base; // Input on view, steps start here
            logic [IW-1:0] nxt, prv; // Stepped inputs with wrap
            logic sub; // Replacement applies this cycle
            assign is_rec = rec_ded && (IDX == vixc_pkg::RECORDER_OUT);
            // Only commands aimed at this output touch it
            assign hit[gi] = kbd_valid && (kbd_out == IDX) && !is_rec; // R1 R6
            assign pub[gi] = (IDX != vixc_pkg::MASTER_OUT) && !is_rec; // R4 R5
            assign base = auto_q[gi] ? seq_in[gi] : sel_q[gi];
            assign nxt = (base == LAST_IN) ? '0 : base + 1'b1;
            assign prv = (base == '0) ? LAST_IN : base - 1'b1;
            // Recorder follows trigger only; keyboards obey their command
            assign sel_d[gi] =
                is_rec ? (trig_rise ? rec_in : sel_q[gi]) : // R6
                !hit[gi] ? sel_q[gi] :
                (kbd_cmd == vixc_pkg::CMD_SELECT) ? kbd_in :
                (kbd_cmd == vixc_pkg::CMD_STEP_NEXT) ? nxt :
                (kbd_cmd == vixc_pkg::CMD_STEP_PREV) ? prv : base;
            // Sequence key resumes, any other command stops the sequence
            assign auto_d[gi] = is_rec ? 1'b0 :
                hit[gi] ? (kbd_cmd == vixc_pkg::CMD_SEQUENCE) : auto_q[gi];
            // Substitution sits on the step value, so dwell is untouched
            assign sub = pub[gi] && auto_q[gi] &&
                         (state_q != vixc_pkg::EX_IDLE) &&
                         (seq_in[gi] == excl_in_q); // R3 R9 R10
            assign vid_d[gi] = (is_rec || !auto_q[gi]) ? sel_q[gi] :
                               sub ? cfg_repl : seq_in[gi]; // R6 R9 R10

            // Monitor state and routed video registers
            always_ff @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    sel_q[gi] <= vixc_pkg::RST_INPUT;
                    auto_q[gi] <= vixc_pkg::RST_AUTO;
                    mon_vid[gi] <= vixc_pkg::RST_INPUT;
                end else begin
                    sel_q[gi] <= sel_d[gi];
                    auto_q[gi] <= auto_d[gi];
                    mon_vid[gi] <= vid_d[gi];
                end
            end
        end
    endgenerate
    assign mon_auto = auto_q;

    // Exclusion state machine; a new trigger beats a same-cycle end
    always_comb begin
        state_d = state_q;
        excl_in_d = excl_in_q;
        case (state_q)
            vixc_pkg::EX_IDLE: begin
                if (man_pick) begin
                    state_d = vixc_pkg::EX_MANUAL; // R11
                    excl_in_d = sel_d[0];
                end else if (tel_trig) begin
                    state_d = vixc_pkg::EX_TELEM; // R13
                    excl_in_d = tel_in;
                end
            end
            vixc_pkg::EX_MANUAL: begin
                if (man_pick) begin
                    excl_in_d = sel_d[0]; // R11
                end else if (seq_master) begin
                    state_d = vixc_pkg::EX_IDLE; // R12
                end
            end
            vixc_pkg::EX_TELEM: begin
                // Plain selections here leave the exclusion alone
                if (tel_trig) begin
                    excl_in_d = tel_in; // R13
                end else if (seq_master) begin
                    state_d = vixc_pkg::EX_IDLE; // R15
                end
            end
            default: begin
                state_d = vixc_pkg::EX_IDLE;
            end
        endcase
    end

    // Exclusion registers; overlay lags alarm by one cycle
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= vixc_pkg::EX_IDLE;
            excl_in_q <= vixc_pkg::RST_INPUT;
            overlay_q <= 1'b0;
        end else begin
            state_q <= state_d;
            excl_in_q <= excl_in_d;
            overlay_q <= (state_d != vixc_pkg::EX_IDLE) && !alarm_q; // R7 R8
        end
    end
    assign excl_active = (state_q != vixc_pkg::EX_IDLE);
    assign excl_input = excl_in_q;
    assign overlay_on = overlay_q;

    // Coax telemetry; receiver address is the one-based input number
    assign coax_req = tel_valid && (tel_path == vixc_pkg::PATH_COAX);
    assign aux_req = tel_valid && (tel_path == vixc_pkg::PATH_AUX);
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            coax_valid_q <= 1'b0;
            coax_addr_q <= 5'h00;
            coax_op_q <= 8'h00;
        end else begin
            coax_valid_q <= coax_req;
            if (coax_req) begin
                coax_addr_q <= {1'b0, tel_in} + 5'h01; // R17
                coax_op_q <= tel_op;
            end
        end
    end
    assign coax_valid = coax_valid_q;
    assign coax_addr = coax_addr_q;
    assign coax_op = coax_op_q;

    // Aux line translator, same receiver numbering as coax except for protocol C
    vixc_aux_xlat u_aux (
        .mclk(mclk),
        .rst_b(rst_b),
        .proto(cfg_aux_proto),
        .in_valid(aux_req),
        .in_addr({1'b0, tel_in} + 5'h01),
        .in_op(tel_op),
        .out_valid(aux_valid),
        .out_hdr(aux_hdr),
        .out_addr(aux_addr),
        .out_op(aux_op)
    );

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence s_pick;
        man_pick && !tel_trig;
    endsequence
    sequence s_excl_on(logic [IW-1:0] v);
        excl_active && (excl_input == v);
    endsequence

    manual_pick_a: assert property (s_pick |=> s_excl_on($past(sel_d[0]))) // R11
        else $error("manual pick did not exclude");
    manual_end_a: assert property (state_q == vixc_pkg::EX_MANUAL &&
        seq_master |=> !excl_active) // R12
        else $error("manual exclusion not ended");
    telem_start_a: assert property (tel_trig && !man_pick
        |=> s_excl_on($past(tel_in))) // R13
        else $error("telemetry did not exclude");
    telem_sel_a: assert property (cfg_mode == vixc_pkg::MODE_TELEMETRY &&
        !excl_active && !tel_trig |=> !excl_active) // R14
        else $error("exclusion without telemetry");
    telem_end_a: assert property (state_q == vixc_pkg::EX_TELEM &&
        seq_master && !tel_trig |=> !excl_active) // R15
        else $error("telemetry exclusion not ended");
    mode_gate_a: assert property (cfg_mode == vixc_pkg::MODE_MANUAL &&
        !excl_active && !man_pick |=> !excl_active) // R2
        else $error("telemetry acted in manual mode");
    overlay_set_a: assert property (excl_active && !$past(alarm_q)
        |-> overlay_on) // R7
        else $error("overlay missing");
    overlay_alarm_a: assert property (alarm_q |=> !overlay_on) // R8
        else $error("overlay shown during alarm");
    master_route_a: assert property (vid_d[0] ==
        (auto_q[0] ? seq_in[0] : sel_q[0])) // R4
        else $error("master monitor substituted");
    manual_route_a: assert property (!auto_q[1] |-> vid_d[1] == sel_q[1]) // R3
        else $error("manual monitor substituted");
    replace_a: assert property (excl_active && auto_q[1] && pub[1] &&
        seq_in[1] == excl_input |-> vid_d[1] == cfg_repl) // R9
        else $error("replacement not shown");
    slot_keep_a: assert property (auto_q[1] && seq_in[1] != excl_input
        |-> vid_d[1] == seq_in[1]) // R10
        else $error("sequence slot disturbed");
    rec_route_a: assert property (rec_ded |-> vid_d[3] == sel_q[3]) // R5
        else $error("recorder output substituted");
    rec_lock_a: assert property (rec_ded && !trig_rise
        |=> $stable(sel_q[3]) && !auto_q[3]) // R6
        else $error("recorder output moved by keyboard");
    isolate_a: assert property (kbd_valid && kbd_out != 2'h1
        |=> $stable(sel_q[1]) && $stable(auto_q[1])) // R1
        else $error("other monitor disturbed");
    coax_addr_a: assert property (coax_req |=> coax_valid &&
        coax_addr == {1'b0, $past(tel_in)} + 5'h01) // R17
        else $error("coax address wrong");
endmodule

/* tb/vixc_kbd_model.sv */
// Model of the operator keyboards sending commands and telemetry.
`timescale 1ns/1ps
module vixc_kbd_model (
    input wire logic mclk,
    output logic kbd_valid,
    output logic [1:0] kbd_cmd,
    output logic [1:0] kbd_out,
    output logic [3:0] kbd_in,
    output logic tel_valid,
    output logic [3:0] tel_kbd,
    output logic [3:0] tel_in,
    output logic tel_path,
    output logic [7:0] tel_op
);
    // Idle at time zero, nothing pending
    initial begin
        kbd_valid = 1'h0;
        kbd_cmd = 2'h0;
        kbd_out = 2'h0;
        kbd_in = 4'h0;
        tel_valid = 1'h0;
        tel_kbd = 4'h0;
        tel_in = 4'h0;
        tel_path = 1'h0;
        tel_op = 8'h00;
    end
    // One-cycle command; fields inverted afterwards so stale data is useless
    task automatic send_cmd(input logic [1:0] c, input logic [1:0] o,
                            input logic [3:0] i);
        @(negedge mclk);
        kbd_valid = 1'h1;
        kbd_cmd = c;
        kbd_out = o;
        kbd_in = i;
        @(negedge mclk);
        kbd_valid = 1'h0;
        kbd_cmd = ~c;
        kbd_out = ~o;
        kbd_in = ~i;
    endtask
    // One-cycle telemetry message, same release habit
    task automatic send_tel(input logic [3:0] k, input logic [3:0] i,
                            input logic p, input logic [7:0] op);
        @(negedge mclk);
        tel_valid = 1'h1;
        tel_kbd = k;
        tel_in = i;
        tel_path = p;
        tel_op = op;
        @(negedge mclk);
        tel_valid = 1'h0;
        tel_kbd = ~k;
        tel_in = ~i;
        tel_path = ~p;
        tel_op = ~op;
    endtask
endmodule

/* tb/vixc_ctrl_bench.sv */
// Self-checking bench for the video input exclusion control.
`timescale 1ns/1ps
module vixc_ctrl_bench;
    logic mclk, rst_b, cfg_mode, cfg_rec_en, alarm_pin, rec_trig_pin;
    logic [3:0] cfg_repl, rec_in;
    logic [1:0] cfg_aux_proto;
    logic kbd_valid, tel_valid, tel_path, coax_valid, aux_valid;
    logic [1:0] kbd_cmd, kbd_out;
    logic [3:0] kbd_in, tel_kbd, tel_in, excl_input, mon_auto;
    logic [7:0] tel_op, coax_op, aux_hdr, aux_addr, aux_op;
    logic [3:0][3:0] seq_in, mon_vid;
    logic [4:0] coax_addr;
    logic excl_active, overlay_on;
    int errors = 0;
    int total_checks = 0;
    vixc_ctrl i_vixc_ctrl (.mclk(mclk), .rst_b(rst_b), .cfg_mode(cfg_mode),
        .cfg_repl(cfg_repl), .cfg_rec_en(cfg_rec_en),
        .cfg_aux_proto(cfg_aux_proto), .kbd_valid(kbd_valid),
        .kbd_cmd(kbd_cmd), .kbd_out(kbd_out), .kbd_in(kbd_in),
        .tel_valid(tel_valid), .tel_kbd(tel_kbd), .tel_in(tel_in),
        .tel_path(tel_path), .tel_op(tel_op), .seq_in(seq_in),
        .alarm_pin(alarm_pin), .rec_trig_pin(rec_trig_pin), .rec_in(rec_in),
        .mon_vid(mon_vid), .mon_auto(mon_auto), .excl_active(excl_active),
        .excl_input(excl_input), .overlay_on(overlay_on),
        .coax_valid(coax_valid), .coax_addr(coax_addr), .coax_op(coax_op),
        .aux_valid(aux_valid), .aux_hdr(aux_hdr), .aux_addr(aux_addr),
        .aux_op(aux_op));
    vixc_kbd_model i_vixc_kbd_model (.mclk(mclk), .kbd_valid(kbd_valid),
        .kbd_cmd(kbd_cmd), .kbd_out(kbd_out), .kbd_in(kbd_in),
        .tel_valid(tel_valid), .tel_kbd(tel_kbd), .tel_in(tel_in),
        .tel_path(tel_path), .tel_op(tel_op));
    // 10 MHz clock
    initial begin
        mclk = 1'h0;
        forever #50 mclk = ~mclk;
    end
    // Single comparison point, four-state exact
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wcyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Recorder output follows trigger only, keyboards ignored
    task automatic t_recorder;
        rec_in = 4'h5;
        rec_trig_pin = 1'h1;
        wcyc(8);
        check(mon_vid[3], 16'h5);
        rec_in = 4'h8;
        i_vixc_kbd_model.send_cmd(vixc_pkg::CMD_SELECT, 2'h3, 4'hA);
        wcyc(4);
        check(mon_vid[3], 16'h5);
    endtask
    // Manual exclusion, substitution, alarm and restore
    task automatic t_manual;
        i_vixc_kbd_model.send_cmd(vixc_pkg::CMD_SELECT, 2'h2, 4'h7);
        wcyc(4);
        check(mon_vid[2], 16'h7);
        check(excl_active, 16'h0);
        i_vixc_kbd_model.send_cmd(vixc_pkg::CMD_SELECT, 2'h0, 4'h5);
        wcyc(4);
        check({excl_active, overlay_on}, 16'h3);
        check(excl_input, 16'h5);
        check(mon_vid[0], 16'h5);
        check(mon_vid[1], 16'h9);
        check(mon_vid[2], 16'h7);
        check(mon_vid[3], 16'h5);
        alarm_pin = 1'h1;
        wcyc(5);
        check({excl_active, overlay_on}, 16'h2);
        alarm_pin = 1'h0;
        wcyc(5);
        check(overlay_on, 16'h1);
        i_vixc_kbd_model.send_cmd(vixc_pkg::CMD_SEQUENCE, 2'h0, 4'h0);
        wcyc(4);
        check({excl_active, overlay_on}, 16'h0);
        check(mon_vid[1], 16'h5);
        check(mon_auto[0], 16'h1);
    endtask
    // Step keys exclude too and wrap at the ends
    task automatic t_step;
        seq_in[0] = 4'hF;
        i_vixc_kbd_model.send_cmd(vixc_pkg::CMD_STEP_NEXT, 2'h0, 4'h3);
        wcyc(4);
        check({excl_active, excl_input}, 16'h10);
        i_vixc_kbd_model.send_cmd(vixc_pkg::CMD_STEP_PREV, 2'h0, 4'h3);
        wcyc(4);
        check({excl_active, excl_input}, 16'h1F);
        check(mon_vid[0], 16'hF);
        i_vixc_kbd_model.send_cmd(vixc_pkg::CMD_SEQUENCE, 2'h0, 4'h0);
        wcyc(4);
        check(excl_active, 16'h0);
    endtask
    // Telemetry mode: only master keyboard telemetry excludes
    task automatic t_telem;
        cfg_mode = vixc_pkg::MODE_TELEMETRY;
        i_vixc_kbd_model.send_cmd(vixc_pkg::CMD_SELECT, 2'h0, 4'h2);
        wcyc(4);
        check(excl_active, 16'h0);
        i_vixc_kbd_model.send_tel(4'h2, 4'h2, vixc_pkg::PATH_COAX, 8'h33);
        // Valid stands for the one cycle after the message
        check(coax_valid, 16'h1);
        wcyc(3);
        check(excl_active, 16'h0);
        check({coax_valid, coax_addr, coax_op}, {1'b0, 5'h3, 8'h33});
        i_vixc_kbd_model.send_tel(4'h1, 4'h5, vixc_pkg::PATH_AUX, 8'h44);
        wcyc(3);
        check({excl_active, excl_input}, 16'h15);
        check(mon_vid[1], 16'h9);
        i_vixc_kbd_model.send_cmd(vixc_pkg::CMD_SEQUENCE, 2'h0, 4'h0);
        wcyc(4);
        check(excl_active, 16'h0);
    endtask
    // Aux line translation for every protocol
    task automatic t_aux;
        logic [7:0] hdr[4];
        hdr = '{8'hA0, 8'hB1, 8'hC2, 8'hFF};
        for (int p = 0; p < 4; p++) begin
            cfg_aux_proto = p[1:0];
            i_vixc_kbd_model.send_tel(4'h3, 4'h4, vixc_pkg::PATH_AUX, 8'h12);
            check(aux_valid, 16'h1);
            wcyc(3);
            check(aux_valid, 16'h0);
            check(aux_hdr, hdr[p]);
            check(aux_addr, (p == 3) ? 16'h4 : 16'h5);
            check(aux_op, (p == 2) ? 16'h21 : 16'h12);
        end
    endtask
    // Recorder off: output 4 obeys keyboards and is a public monitor
    task automatic t_norec;
        cfg_rec_en = 1'h0;
        i_vixc_kbd_model.send_cmd(vixc_pkg::CMD_SEQUENCE, 2'h3, 4'h0);
        wcyc(2);
        check(mon_auto[3], 16'h1);
        i_vixc_kbd_model.send_tel(4'h1, 4'h5, vixc_pkg::PATH_COAX, 8'h55);
        check(coax_valid, 16'h1);
        wcyc(3);
        check(mon_vid[3], 16'h9);
        i_vixc_kbd_model.send_cmd(vixc_pkg::CMD_SEQUENCE, 2'h0, 4'h0);
        wcyc(4);
        check({excl_active, mon_vid[3]}, 16'h5);
    endtask
    // Watchdog at 2000 cycles, far beyond the roughly 130 cycles needed
    initial begin
        #200000;
        errors++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        rst_b = 1'h0;
        cfg_mode = vixc_pkg::MODE_MANUAL;
        cfg_repl = 4'h9;
        cfg_rec_en = 1'h1;
        cfg_aux_proto = vixc_pkg::AUX_NATIVE;
        alarm_pin = 1'h0;
        rec_trig_pin = 1'h0;
        rec_in = 4'h0;
        seq_in = {4'h5, 4'h5, 4'h5, 4'h1};
        wcyc(10);
        check({mon_auto, excl_active, overlay_on}, 16'h3C);
        rst_b = 1'h1;
        wcyc(2);
        t_recorder();
        t_manual();
        t_step();
        t_telem();
        t_aux();
        t_norec();
        report_and_stop();
    end
endmodule
